// [logic/login_host.sv]
// host initiator end: builds the login request and send transfers
`timescale 1ns/10ps
`include "login_link_params.svh"
module login_host (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // link
   login_link_if.host       link,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // interrupt
   output logic             irq
);
   typedef enum logic [1:0] {H_IDLE, H_SEND, H_TERM} hstate_t;
   hstate_t     state_ff;
   logic [3:0]  ctrl_ff;
   logic [3:0]  irq_ff;
   logic [3:0]  mask_ff;
   logic [3:0]  rejoin_ff;
   logic [63:0] sink_ff;
   logic [63:0] resp_addr_ff;
   logic [15:0] handle_ff;
   logic [63:0] agent_ff;
   logic [7:0]  last_status_ff;
   logic [7:0]  data_ff;
   logic        data_full_ff;
   logic [1:0]  term_ff;
   logic        logged_ff;
   logic        prep_ok_ff;
   login_link_pkg::send_kind_t kind_ff;
   logic [3:0]  ev;
   function automatic logic [31:0] lo_word(input logic [63:0] v);
      lo_word = v[31:0];
   endfunction : lo_word
   // register writes
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         mask_ff      <= 4'h0;
         rejoin_ff    <= 4'h0;
         sink_ff      <= 64'h0;
         resp_addr_ff <= 64'h0;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `REG_MASK:         mask_ff <= reg_wdata[3:0];
            `REG_RECONNECT:    rejoin_ff <= reg_wdata[3:0];
            `REG_STAT_SINK_LO: sink_ff[31:0] <= reg_wdata;
            `REG_STAT_SINK_HI: sink_ff[63:32] <= reg_wdata;
            `REG_RESP_LO:      resp_addr_ff[31:0] <= reg_wdata;
            `REG_RESP_HI:      resp_addr_ff[63:32] <= reg_wdata;
            default:           ;
         endcase
      end
   end
   // events: login done, login failed, status received, send finished
   assign ev[`IRQ_DONE_BIT]   = link.resp_valid;
   assign ev[`IRQ_FAIL_BIT]   = link.status_valid && link.status_code == `STATUS_REJECT;
   assign ev[`IRQ_STATUS_BIT] = link.status_valid;
   assign ev[`IRQ_SEND_BIT]   = link.send_valid && link.send_last;
   // set wins over a write-one clear in the same cycle
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         irq_ff <= 4'h0;
         irq    <= 1'b0;
      end
      else
      begin
         irq_ff <= (irq_ff & ~((reg_wr && reg_addr == `REG_IRQ) ? reg_wdata[3:0] : 4'h0)) | ev;
         irq    <= |(irq_ff & mask_ff);
      end
   end
   // login answers and status from the device
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         handle_ff      <= 16'h0000;
         agent_ff       <= 64'h0;
         logged_ff      <= 1'b0;
         last_status_ff <= 8'h00;
         prep_ok_ff     <= 1'b0;
      end
      else
      begin
         if (link.resp_valid)
         begin
            handle_ff <= link.resp.session_handle;
            agent_ff  <= link.resp.agent_base;
            logged_ff <= link.resp.length == `RESPONSE_LEN_BYTES;
         end
         if (link.status_valid)
         begin
            last_status_ff <= link.status_code;
            prep_ok_ff     <= kind_ff == login_link_pkg::SEND_PREP && link.status_code == `STATUS_OK;
         end
      end
   end
   // login request, one cycle, fixed fields per the exchange
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         link.req_valid <= 1'b0;
         link.req       <= '0;
      end
      else
      begin
         link.req_valid <= reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_LOGIN_BIT] && state_ff == H_IDLE;
         link.req.password      <= `PASSWORD_VALUE;
         link.req.secret_size   <= `SECRET_SIZE_VALUE;
         link.req.response_addr <= resp_addr_ff;
         link.req.response_len  <= `RESPONSE_BUF_BYTES;
         link.req.notify        <= 1'b1;
         link.req.req_format    <= 2'h0;
         link.req.exclusive     <= 1'b1;
         link.req.rejoin_exp    <= rejoin_ff;
         link.req.operation     <= `OP_LOGIN;
         link.req.lun           <= `LUN_VALUE;
         link.req.status_sink   <= sink_ff;
      end
   end
   // send data staging: one byte per write to the send data register
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         data_ff      <= 8'h00;
         data_full_ff <= 1'b0;
         ctrl_ff      <= 4'h0;
      end
      else
      begin
         if (reg_wr && reg_addr == `REG_SEND_DATA)
         begin
            data_ff      <= reg_wdata[7:0];
            data_full_ff <= 1'b1;
         end
         else if (state_ff == H_SEND)
            data_full_ff <= 1'b0;
         if (reg_wr && reg_addr == `REG_CTRL)
            ctrl_ff <= reg_wdata[3:0];
      end
   end
   // send machine; text commands close with CR, LF, zero
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_ff         <= H_IDLE;
         kind_ff          <= login_link_pkg::SEND_TEXT;
         term_ff          <= 2'h0;
         link.send_valid  <= 1'b0;
         link.send_kind   <= login_link_pkg::SEND_TEXT;
         link.send_handle <= 16'h0000;
         link.send_byte   <= 8'h00;
         link.send_last   <= 1'b0;
      end
      else
      begin
         link.send_valid  <= 1'b0;
         link.send_last   <= 1'b0;
         link.send_handle <= handle_ff;
         case (state_ff)
            H_IDLE:
            begin
               if (data_full_ff && logged_ff)
               begin
                  if (ctrl_ff[`CTRL_RAW_BIT] && prep_ok_ff)
                     kind_ff <= login_link_pkg::SEND_RAW;
                  else if (ctrl_ff[`CTRL_PREP_BIT])
                     kind_ff <= login_link_pkg::SEND_PREP;
                  else
                     kind_ff <= login_link_pkg::SEND_TEXT;
                  if (!ctrl_ff[`CTRL_RAW_BIT] || prep_ok_ff)
                     state_ff <= H_SEND;
               end
            end
            H_SEND:
            begin
               link.send_valid <= 1'b1;
               link.send_kind  <= kind_ff;
               link.send_byte  <= data_ff;
               if (ctrl_ff[`CTRL_SEND_BIT])
               begin
                  if (kind_ff == login_link_pkg::SEND_RAW)
                  begin
                     link.send_last <= 1'b1;
                     state_ff       <= H_IDLE;
                  end
                  else
                  begin
                     term_ff  <= 2'h0;
                     state_ff <= H_TERM;
                  end
               end
               else
                  state_ff <= H_IDLE;
            end
            H_TERM:
            begin
               link.send_valid <= 1'b1;
               link.send_kind  <= kind_ff;
               term_ff         <= term_ff + 2'h1;
               case (term_ff)
                  2'h0:    link.send_byte <= `CR_BYTE;
                  2'h1:    link.send_byte <= `LF_BYTE;
                  default:
                  begin
                     link.send_byte <= `NUL_BYTE;
                     link.send_last <= 1'b1;
                     state_ff       <= H_IDLE;
                  end
               endcase
            end
            default: state_ff <= H_IDLE;
         endcase
      end
   end
   // register read, data one cycle later
   always_ff @(posedge core_clk)
   begin
      if (reset)
         reg_rdata <= 32'h0;
      else if (reg_rd)
      begin
         case (reg_addr)
            `REG_CTRL:        reg_rdata <= {28'h0, ctrl_ff};
            `REG_STATUS:      reg_rdata <= {28'h0, prep_ok_ff, data_full_ff, state_ff != H_IDLE, logged_ff};
            `REG_IRQ:         reg_rdata <= {28'h0, irq_ff};
            `REG_MASK:        reg_rdata <= {28'h0, mask_ff};
            `REG_RECONNECT:   reg_rdata <= {28'h0, rejoin_ff};
            `REG_HANDLE:      reg_rdata <= {16'h0, handle_ff};
            `REG_AGENT_LO:    reg_rdata <= lo_word(agent_ff);
            `REG_AGENT_HI:    reg_rdata <= agent_ff[63:32];
            `REG_STAT_SINK_LO: reg_rdata <= lo_word(sink_ff);
            `REG_STAT_SINK_HI: reg_rdata <= sink_ff[63:32];
            `REG_RESP_LO:     reg_rdata <= lo_word(resp_addr_ff);
            `REG_RESP_HI:     reg_rdata <= resp_addr_ff[63:32];
            `REG_LAST_STATUS: reg_rdata <= {24'h0, last_status_ff};
            default:          reg_rdata <= 32'h0;
         endcase
      end
      else
         reg_rdata <= 32'h0;
   end
endmodule : login_host

// [logic/login_link_params.svh]
// constants for the login exchange between host initiator and processor device
`ifndef LOGIN_LINK_PARAMS_SVH
`define LOGIN_LINK_PARAMS_SVH
`define PASSWORD_VALUE      32'h52544320
`define SECRET_SIZE_VALUE   16'h0000
`define RESPONSE_BUF_BYTES  16'h000c
`define OP_LOGIN            4'h0
`define LUN_VALUE           16'h0001
`define RESPONSE_LEN_BYTES  16'h000c
`define STATUS_OK           8'h00
`define STATUS_REJECT       8'h01
`define STATUS_RAW_OK       8'h02
`define STATUS_RAW_ILLEGAL  8'h03
`define REG_CTRL            4'h0
`define REG_STATUS          4'h1
`define REG_IRQ             4'h2
`define REG_MASK            4'h3
`define REG_RECONNECT       4'h4
`define REG_HANDLE          4'h5
`define REG_AGENT_LO        4'h6
`define REG_AGENT_HI        4'h7
`define REG_STAT_SINK_LO    4'h8
`define REG_STAT_SINK_HI    4'h9
`define REG_RESP_LO         4'ha
`define REG_RESP_HI         4'hb
`define REG_SEND_DATA       4'hc
`define REG_LAST_STATUS     4'hd
`define CTRL_LOGIN_BIT      0
`define CTRL_SEND_BIT       1
`define CTRL_RAW_BIT        2
`define CTRL_PREP_BIT       3
`define IRQ_DONE_BIT        0
`define IRQ_FAIL_BIT        1
`define IRQ_STATUS_BIT      2
`define IRQ_SEND_BIT        3
`define CR_BYTE             8'h0d
`define LF_BYTE             8'h0a
`define NUL_BYTE            8'h00
`endif

// [logic/login_link_pkg.sv]
// types shared by both ends of the login exchange
package login_link_pkg;
   typedef struct packed
   {
      logic [31:0] password;
      logic [63:0] response_addr;
      logic        notify;
      logic [1:0]  req_format;
      logic        exclusive;
      logic [3:0]  rejoin_exp;
      logic [3:0]  operation;
      logic [15:0] lun;
      logic [15:0] secret_size;
      logic [15:0] response_len;
      logic [63:0] status_sink;
   } login_req_t;

   typedef struct packed
   {
      logic [15:0] length;
      logic [15:0] session_handle;
      logic [63:0] agent_base;
   } login_resp_t;

   typedef enum logic [1:0]
   {
      SEND_TEXT,
      SEND_RAW,
      SEND_PREP
   } send_kind_t;
endpackage : login_link_pkg

// [logic/login_link_if.sv]
// link between host initiator and processor device
`timescale 1ns/10ps
interface login_link_if;
   logic                      req_valid;
   login_link_pkg::login_req_t req;
   logic                      resp_valid;
   login_link_pkg::login_resp_t resp;
   logic                      send_valid;
   login_link_pkg::send_kind_t send_kind;
   logic [15:0]               send_handle;
   logic [7:0]                send_byte;
   logic                      send_last;
   logic                      status_valid;
   logic [63:0]               status_addr;
   logic [7:0]                status_code;

   modport host
   (
      output req_valid, req, send_valid, send_kind, send_handle, send_byte, send_last,
      input  resp_valid, resp, status_valid, status_addr, status_code
   );
   modport device
   (
      input  req_valid, req, send_valid, send_kind, send_handle, send_byte, send_last,
      output resp_valid, resp, status_valid, status_addr, status_code
   );
endinterface : login_link_if

// [logic/login_device.sv]
// processor device end: checks logins, answers, reports status
`timescale 1ns/10ps
`include "login_link_params.svh"
module login_device #(
   parameter logic [63:0] AGENT_BASE   = 64'h0000_ffff_f001_0000,
   parameter logic [15:0] HANDLE_SEED  = 16'h0001
) (
   // clock and reset
   input  wire logic   core_clk,
   input  wire logic   reset,
   // link
   login_link_if.device link,
   // user side
   output logic [7:0]  rx_byte,
   output logic        rx_valid,
   output logic        rx_raw,
   output logic        session_open,
   output logic [3:0]  rejoin_exp
);
   logic [15:0] handle_ff;
   logic        logged_ff;
   logic        prep_ok_ff;
   logic        in_raw_ff;
   logic [63:0] sink_ff;
   logic        good;

   // fixed fields other than req_format hold required values
   always_comb
   begin
      good = link.req.password == `PASSWORD_VALUE && link.req.secret_size == `SECRET_SIZE_VALUE
          && link.req.notify && link.req.exclusive && link.req.operation == `OP_LOGIN
          && link.req.lun == `LUN_VALUE && link.req.response_len >= `RESPONSE_BUF_BYTES;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         link.resp_valid <= 1'b0;
         link.resp       <= '0;
         handle_ff       <= HANDLE_SEED;
         logged_ff       <= 1'b0;
         sink_ff         <= 64'h0;
         rejoin_exp      <= 4'h0;
      end
      else
      begin
         link.resp_valid <= link.req_valid && good;
         if (link.req_valid)
         begin
            sink_ff <= link.req.status_sink;
            if (good)
            begin
               link.resp.length         <= `RESPONSE_LEN_BYTES;
               link.resp.session_handle <= handle_ff;
               link.resp.agent_base     <= AGENT_BASE;
               handle_ff                <= handle_ff + 16'h0001;
               logged_ff                <= 1'b1;
               rejoin_exp               <= link.req.rejoin_exp;
            end
         end
      end
   end

   // status to the sink for login and send outcomes
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         link.status_valid <= 1'b0;
         link.status_addr  <= 64'h0;
         link.status_code  <= 8'h00;
      end
      else
      begin
         link.status_valid <= 1'b0;
         if (link.req_valid)
         begin
            link.status_valid <= 1'b1;
            link.status_addr  <= link.req.status_sink;
            link.status_code  <= good ? `STATUS_OK : `STATUS_REJECT;
         end
         else if (link.send_valid && link.send_last)
         begin
            link.status_valid <= 1'b1;
            link.status_addr  <= sink_ff;
            if (!logged_ff || link.send_handle != link.resp.session_handle)
               link.status_code <= `STATUS_REJECT;
            else if (link.send_kind == login_link_pkg::SEND_RAW && !prep_ok_ff && !in_raw_ff)
               link.status_code <= `STATUS_RAW_ILLEGAL;
            else
               link.status_code <= link.send_kind == login_link_pkg::SEND_RAW ? `STATUS_RAW_OK : `STATUS_OK;
         end
      end
   end

   // send path: text bytes or raw block bytes
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rx_byte    <= 8'h00;
         rx_valid   <= 1'b0;
         rx_raw     <= 1'b0;
         prep_ok_ff <= 1'b0;
         in_raw_ff  <= 1'b0;
      end
      else
      begin
         rx_valid <= link.send_valid && logged_ff && link.send_handle == link.resp.session_handle
                     && (link.send_kind != login_link_pkg::SEND_RAW || prep_ok_ff || in_raw_ff);
         rx_byte  <= link.send_byte;
         rx_raw   <= link.send_kind == login_link_pkg::SEND_RAW;
         if (link.send_valid)
         begin
            if (link.send_kind == login_link_pkg::SEND_RAW)
            begin
               in_raw_ff  <= (prep_ok_ff || in_raw_ff) && !link.send_last;
               prep_ok_ff <= 1'b0;
            end
            else if (link.send_last)
            begin
               prep_ok_ff <= link.send_kind == login_link_pkg::SEND_PREP;
               in_raw_ff  <= 1'b0;
            end
         end
      end
   end

   assign session_open = logged_ff;
endmodule : login_device

// [verification/login_link_monitor.sv]
// assertions on the link between host and device
`timescale 1ns/10ps
`include "login_link_params.svh"
module login_link_monitor (
   // clock and reset
   input wire logic                        core_clk,
   input wire logic                        reset,
   // login request and answer
   input wire logic                        req_valid,
   input wire login_link_pkg::login_req_t  req,
   input wire logic                        resp_valid,
   input wire login_link_pkg::login_resp_t resp,
   // send path
   input wire logic                        send_valid,
   input wire login_link_pkg::send_kind_t  send_kind,
   input wire logic [15:0]                 send_handle,
   input wire logic [7:0]                  send_byte,
   input wire logic                        send_last,
   // status
   input wire logic                        status_valid,
   input wire logic [63:0]                 status_addr,
   input wire logic [7:0]                  status_code
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic [15:0] handle_ff;
   logic [63:0] sink_ff;

   // handle as the host last learned it
   always_ff @(posedge core_clk)
   begin
      if (reset)
         handle_ff <= 16'h0000;
      else if (resp_valid)
         handle_ff <= resp.session_handle;
   end

   // sink given with the last login
   always_ff @(posedge core_clk)
   begin
      if (reset)
         sink_ff <= 64'h0;
      else if (req_valid)
         sink_ff <= req.status_sink;
   end

   sequence s_cr;
      send_valid && send_kind != login_link_pkg::SEND_RAW && send_byte == `CR_BYTE;
   endsequence
   sequence s_tail;
      ##[1:4] (send_valid && send_byte == `LF_BYTE) ##[1:4] (send_valid && send_last && send_byte == `NUL_BYTE);
   endsequence

   property p_pw;
      req_valid |-> req.password == `PASSWORD_VALUE;
   endproperty
   a_pw: assert property (p_pw) else $error("bad password");
   property p_sizes;
      req_valid |-> req.secret_size == `SECRET_SIZE_VALUE && req.response_len == `RESPONSE_BUF_BYTES;
   endproperty
   a_sizes: assert property (p_sizes) else $error("bad sizes");
   property p_flags;
      req_valid |-> req.notify && req.exclusive;
   endproperty
   a_flags: assert property (p_flags) else $error("bad flags");
   property p_op_lun;
      req_valid |-> req.operation == `OP_LOGIN && req.lun == `LUN_VALUE;
   endproperty
   a_op_lun: assert property (p_op_lun) else $error("bad function or unit");
   property p_login_status;
      req_valid |=> status_valid && (status_code == `STATUS_OK || status_code == `STATUS_REJECT);
   endproperty
   a_login_status: assert property (p_login_status) else $error("no login status");
   property p_sink;
      status_valid |-> status_addr == sink_ff;
   endproperty
   a_sink: assert property (p_sink) else $error("status to wrong sink");
   property p_resp_len;
      resp_valid |-> resp.length == `RESPONSE_LEN_BYTES;
   endproperty
   a_resp_len: assert property (p_resp_len) else $error("bad response length");
   property p_resp_ok;
      resp_valid |-> status_valid && status_code == `STATUS_OK && $past(req_valid);
   endproperty
   a_resp_ok: assert property (p_resp_ok) else $error("response without good login");
   property p_handle;
      send_valid |-> send_handle == handle_ff;
   endproperty
   a_handle: assert property (p_handle) else $error("stale handle");
   property p_text_tail;
      s_cr |-> s_tail;
   endproperty
   a_text_tail: assert property (p_text_tail) else $error("bad terminator");
   property p_send_status;
      send_valid && send_last |=> status_valid;
   endproperty
   a_send_status: assert property (p_send_status) else $error("no send status");
endmodule : login_link_monitor

// [verification/serial_bus_login_orb_tb.sv]
// bench joining host and device, plus a faulty host driving a second device
`timescale 1ns/10ps
`include "login_link_params.svh"
module serial_bus_login_orb_tb;
   localparam logic [63:0] AGENT = 64'h0000_1234_0000_5678;
   localparam logic [15:0] SEED  = 16'h00a5;
   logic        core_clk;
   logic        reset;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        irq;
   logic [7:0]  rx_byte;
   logic        rx_valid;
   logic        rx_raw;
   logic        session_open;
   logic [3:0]  rejoin_exp;
   logic [7:0]  rx_q[$];
   int          miscompares;
   int          compares;
   login_link_if link();
   login_link_if link2();

   login_host login_host_inst (.core_clk(core_clk), .reset(reset), .link(link.host), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   login_device #(.AGENT_BASE(AGENT), .HANDLE_SEED(SEED)) login_device_inst (.core_clk(core_clk),
      .reset(reset), .link(link.device), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_raw(rx_raw),
      .session_open(session_open), .rejoin_exp(rejoin_exp));
   login_device #(.AGENT_BASE(AGENT), .HANDLE_SEED(SEED)) login_device_inst2 (.core_clk(core_clk),
      .reset(reset), .link(link2.device), .rx_byte(), .rx_valid(), .rx_raw(), .session_open(), .rejoin_exp());
   login_link_monitor login_link_monitor_inst (.core_clk(core_clk), .reset(reset), .req_valid(link.req_valid),
      .req(link.req), .resp_valid(link.resp_valid), .resp(link.resp), .send_valid(link.send_valid),
      .send_kind(link.send_kind), .send_handle(link.send_handle), .send_byte(link.send_byte),
      .send_last(link.send_last), .status_valid(link.status_valid), .status_addr(link.status_addr),
      .status_code(link.status_code));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
      if (rx_valid === 1'b1)
         rx_q.push_back(rx_byte);

   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk = 32'hffff_ffff);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata & msk, exp);
   endtask : rd

   // 0: send byte, 1: status, 2: status of the second link
   task automatic wait_link(input int which);
      int n;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while ((which == 0 ? link.send_valid : which == 1 ? link.status_valid : link2.status_valid) !== 1'b1 && n < 60);
      if (n >= 60)
      begin
         miscompares++;
         $display("mismatch at %0t: link wait ran out", $time);
         wrap_up();
      end
   endtask : wait_link

   task automatic reset_values();
      rd(`REG_IRQ, 32'h0);
      rd(`REG_MASK, 32'h0);
      wr(4'hf, 32'hffff_ffff);
      rd(4'hf, 32'h0);
      rd(4'he, 32'h0);
      check({31'h0, session_open}, 32'h0);
   endtask : reset_values

   task automatic login_ok();
      wr(`REG_STAT_SINK_LO, 32'h0000_2000);
      wr(`REG_STAT_SINK_HI, 32'h0000_0001);
      wr(`REG_RESP_LO, 32'h0000_3000);
      wr(`REG_RECONNECT, 32'h3);
      wr(`REG_MASK, 32'hf);
      wr(`REG_CTRL, 32'h1);
      wait_link(1);
      check({24'h0, link.status_code}, {24'h0, `STATUS_OK});
      check(link.status_addr[63:32], 32'h1);
      repeat (3) @(posedge core_clk);
      rd(`REG_HANDLE, {16'h0, SEED});
      rd(`REG_AGENT_LO, AGENT[31:0]);
      rd(`REG_AGENT_HI, AGENT[63:32]);
      rd(`REG_RESP_LO, 32'h0000_3000);
      rd(`REG_STATUS, 32'h1);
      rd(`REG_IRQ, 32'h1, 32'h3);
      check({28'h0, rejoin_exp}, 32'h3);
      check({30'h0, session_open, irq}, 32'h3);
      wr(`REG_IRQ, 32'hf);
      repeat (2) @(posedge core_clk);
      #1;
      check({31'h0, irq}, 32'h0);
   endtask : login_ok

   task automatic text_send();
      logic [7:0] tx [5] = '{8'h41, 8'h42, `CR_BYTE, `LF_BYTE, `NUL_BYTE};
      rx_q.delete();
      wr(`REG_CTRL, 32'h0);
      wr(`REG_SEND_DATA, 32'h41);
      wait_link(0);
      wr(`REG_CTRL, 32'h2);
      wr(`REG_SEND_DATA, 32'h42);
      wait_link(1);
      repeat (2) @(posedge core_clk);
      check(32'(rx_q.size()), 32'h5);
      for (int i = 0; i < 5; i++)
         check({24'h0, rx_q[i]}, {24'h0, tx[i]});
      rd(`REG_LAST_STATUS, {24'h0, `STATUS_OK});
   endtask : text_send

   task automatic raw_send();
      rx_q.delete();
      wr(`REG_CTRL, 32'h6);
      wr(`REG_SEND_DATA, 32'h55);
      repeat (20) @(posedge core_clk);
      check(32'(rx_q.size()), 32'h0);
      rd(`REG_STATUS, 32'h5);
      // refused byte stays staged and leaves as the preparation command
      wr(`REG_CTRL, 32'ha);
      wait_link(1);
      rd(`REG_LAST_STATUS, {24'h0, `STATUS_OK});
      rd(`REG_STATUS, 32'h9);
      rx_q.delete();
      wr(`REG_MASK, 32'h0);
      wr(`REG_IRQ, 32'hf);
      wr(`REG_CTRL, 32'h6);
      wr(`REG_SEND_DATA, 32'h0d);
      wait_link(1);
      repeat (2) @(posedge core_clk);
      // raw carriage return must not pick up a terminator
      check({23'h0, rx_raw, rx_q[0]}, 32'h10d);
      check(32'(rx_q.size()), 32'h1);
      rd(`REG_LAST_STATUS, {24'h0, `STATUS_RAW_OK});
      rd(`REG_IRQ, 32'h8, 32'h8);
      check({31'h0, irq}, 32'h0);
      wr(`REG_MASK, 32'hf);
      repeat (2) @(posedge core_clk);
      #1;
      check({31'h0, irq}, 32'h1);
   endtask : raw_send

   task automatic bad_login();
      login_link_pkg::login_req_t r;
      login_link_pkg::login_req_t rr;
      r = '{`PASSWORD_VALUE, 64'h3000, 1'b1, 2'h0, 1'b1, 4'h0, `OP_LOGIN, `LUN_VALUE, 16'h0, 16'hc, 64'h4000};
      for (int i = 0; i < 4; i++)
      begin
         rr = r;
         rr.password[0] = (i == 0) ? 1'b1 : rr.password[0];
         rr.lun = (i == 1) ? 16'h0002 : rr.lun;
         rr.operation = (i == 2) ? 4'h1 : rr.operation;
         @(posedge core_clk);
         link2.req <= rr;
         link2.req_valid <= 1'b1;
         @(posedge core_clk);
         link2.req_valid <= 1'b0;
         wait_link(2);
         check({24'h0, link2.status_code}, {24'h0, (i == 3) ? `STATUS_OK : `STATUS_REJECT});
         check({31'h0, link2.resp_valid}, {31'h0, i == 3});
      end
      check({16'h0, link2.resp.length}, 32'hc);
      // wrong handle, then raw with no preparation
      for (int k = 0; k < 2; k++)
      begin
         @(posedge core_clk);
         link2.send_handle <= (k == 0) ? SEED + 16'h0001 : SEED;
         link2.send_kind <= login_link_pkg::SEND_RAW;
         link2.send_last <= 1'b1;
         link2.send_valid <= 1'b1;
         @(posedge core_clk);
         link2.send_valid <= 1'b0;
         wait_link(2);
         check({24'h0, link2.status_code}, {24'h0, (k == 0) ? `STATUS_REJECT : `STATUS_RAW_ILLEGAL});
      end
   endtask : bad_login

   initial
   begin
      reset = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      miscompares = 0;
      compares = 0;
      link2.req_valid = 1'b0;
      link2.req = '0;
      link2.send_valid = 1'b0;
      link2.send_kind = login_link_pkg::SEND_TEXT;
      link2.send_handle = 16'h0;
      link2.send_byte = 8'h0;
      link2.send_last = 1'b0;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      reset_values();
      login_ok();
      text_send();
      raw_send();
      bad_login();
      wrap_up();
   end
endmodule : serial_bus_login_orb_tb
